// ==== hdl/udr_decoder.sv ====
// Device request decoder: takes setup packets, classifies and applies them
`timescale 1ns/10ps
`include "udr_map.svh"

module udr_decoder
#(
    parameter int NUM_EP = 16
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic setup_start_in,
    input wire logic [3:0] pid_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    input wire logic pkt_end_in,
    input wire logic status_done_in,
    output logic ack_out,
    output udr_pkg::udr_cmd_t cmd_out,
    output logic status_stage_out,
    output logic [3:0] status_pid_out,
    output logic [6:0] dev_addr_out,
    output logic [7:0] config_out,
    output logic [7:0] alt_setting_out,
    output logic configured_out,
    output logic wakeup_en_out,
    output logic [NUM_EP-1:0] ep_stall_out,
    output logic bad_setup_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_LOAD,
        ST_DECODE,
        ST_DATA,
        ST_STATUS
    } udr_state_t;

    udr_state_t state_reg;
    logic [3:0] count_reg;
    logic ack_reg;
    udr_pkg::udr_cmd_t cmd_reg;
    logic status_reg;
    logic [3:0] status_pid_reg;
    logic [6:0] addr_reg;
    logic [6:0] addr_pend_reg;
    logic addr_pend_valid_reg;
    logic [7:0] config_reg;
    logic configured_reg;
    logic [7:0] alt_reg;
    logic wakeup_reg;
    logic [NUM_EP-1:0] stall_reg;
    logic bad_reg;
    udr_pkg::udr_setup_t setup;
    udr_pkg::udr_cat_t cat_now;
    udr_pkg::udr_dir_t dir_now;
    logic supp_now;
    logic wr_en;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic udr_pkg::udr_cat_t category(input logic [7:0] rt);
        unique case (rt[6:5])
            `UDR_TYPE_STD: category = udr_pkg::UDR_CAT_STD;
            `UDR_TYPE_CLASS: category = udr_pkg::UDR_CAT_CLASS;
            `UDR_TYPE_VENDOR: category = udr_pkg::UDR_CAT_VENDOR;
            default: category = udr_pkg::UDR_CAT_BAD;
        endcase
    endfunction

    function automatic logic is_std(input udr_pkg::udr_setup_t s, input logic [7:0] code);
        is_std = (category(s.req_type) == udr_pkg::UDR_CAT_STD) && (s.request == code);
    endfunction

    function automatic logic [3:0] ep_of(input logic [15:0] idx);
        ep_of = idx[3:0];
    endfunction

    // Eight byte store keeps the packet off the decode path
    udr_setup_buf u_buf
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(wr_en),
        .wr_addr_in(count_reg[2:0]),
        .wr_data_in(byte_in),
        .rd_data_out(setup)
    );

    assign wr_en = (state_reg == ST_RECV) && byte_valid_in && (count_reg < `UDR_SETUP_BYTES);

    // ----------------------------------------------------------------
    // Classification
    // ----------------------------------------------------------------
    always_comb
    begin
        cat_now = category(setup.req_type);
        supp_now = 1'b1;
        dir_now = udr_pkg::UDR_DIR_NONE;
        if (cat_now == udr_pkg::UDR_CAT_STD)
        begin
            unique case (setup.request)
                `UDR_REQ_GET_STATUS, `UDR_REQ_GET_DESC, `UDR_REQ_GET_CONFIG,
                `UDR_REQ_GET_INTF: dir_now = udr_pkg::UDR_DIR_IN;
                `UDR_REQ_SET_DESC: dir_now = udr_pkg::UDR_DIR_OUT;
                `UDR_REQ_SYNC_FRAME: dir_now = udr_pkg::UDR_DIR_OUT;
                `UDR_REQ_CLEAR_FEATURE, `UDR_REQ_SET_FEATURE, `UDR_REQ_SET_ADDRESS,
                `UDR_REQ_SET_CONFIG, `UDR_REQ_SET_INTF: dir_now = udr_pkg::UDR_DIR_NONE;
                default: supp_now = 1'b0;
            endcase
        end
        else if (cat_now == udr_pkg::UDR_CAT_BAD)
        begin
            supp_now = 1'b0;
        end
        else
        begin
            // Class and vendor: same format, direction from type bit 7 when length is nonzero, else none
            if (setup.length != 16'h0000)
            begin
                dir_now = setup.req_type[7] ? udr_pkg::UDR_DIR_IN : udr_pkg::UDR_DIR_OUT;
            end
            // Before configuration only enumeration traffic is serviced
            supp_now = config_reg != `UDR_RST_CONFIG;
        end
    end

    // ----------------------------------------------------------------
    // Control transfer sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 4'h0;
            bad_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE, ST_DATA, ST_STATUS:
                begin
                    if (state_reg == ST_STATUS && status_done_in)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    // A new setup aborts a running data or status stage; during ST_RECV, ST_LOAD and ST_DECODE it is ignored
                    if (setup_start_in)
                    begin
                        state_reg <= ST_RECV;
                        count_reg <= 4'h0;
                    end
                    else if (state_reg == ST_DATA && status_done_in)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RECV:
                begin
                    if (wr_en)
                    begin
                        count_reg <= count_reg + 4'h1;
                    end
                    if (pkt_end_in)
                    begin
                        // Short packet or wrong PID: drop it, nothing is applied; bytes past the eighth are ignored
                        if (count_reg == `UDR_SETUP_BYTES && pid_in == `UDR_PID_DATA0)
                        begin
                            state_reg <= ST_LOAD;
                            bad_reg <= 1'b0;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                            bad_reg <= 1'b1;
                        end
                    end
                end
                ST_LOAD: state_reg <= ST_DECODE;
                ST_DECODE: state_reg <= (dir_now == udr_pkg::UDR_DIR_NONE) ? ST_STATUS : ST_DATA;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Handshake and status stage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_reg <= 1'b0;
            status_reg <= 1'b0;
            status_pid_reg <= `UDR_PID_DATA1;
        end
        else
        begin
            ack_reg <= (state_reg == ST_RECV) && pkt_end_in;
            status_reg <= (state_reg == ST_DECODE && dir_now == udr_pkg::UDR_DIR_NONE) ||
                          (state_reg == ST_STATUS && !status_done_in && !setup_start_in);
            status_pid_reg <= `UDR_PID_DATA1;
        end
    end

    // ----------------------------------------------------------------
    // Decoded command
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cmd_reg <= '0;
        end
        else
        begin
            cmd_reg.valid <= state_reg == ST_DECODE;
            if (state_reg == ST_DECODE)
            begin
                cmd_reg.cat <= cat_now;
                cmd_reg.dir <= dir_now;
                cmd_reg.request <= setup.request;
                cmd_reg.value <= setup.value;
                cmd_reg.index <= setup.index;
                cmd_reg.length <= setup.length;
                cmd_reg.supported <= supp_now;
            end
        end
    end

    // ----------------------------------------------------------------
    // Device state effects
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_reg <= `UDR_RST_ADDR;
            addr_pend_reg <= `UDR_RST_ADDR;
            addr_pend_valid_reg <= 1'b0;
            config_reg <= `UDR_RST_CONFIG;
            configured_reg <= 1'b0;
            alt_reg <= 8'h00;
            wakeup_reg <= 1'b0;
            stall_reg <= '0;
        end
        else
        begin
            if (state_reg == ST_RECV)
            begin
                addr_pend_valid_reg <= 1'b0;
            end
            // New address takes effect after the status stage completes
            if (addr_pend_valid_reg && state_reg == ST_STATUS && status_done_in)
            begin
                addr_reg <= addr_pend_reg;
                addr_pend_valid_reg <= 1'b0;
            end
            if (state_reg == ST_DECODE)
            begin
                if (is_std(setup, `UDR_REQ_SET_ADDRESS))
                begin
                    addr_pend_reg <= setup.value[6:0];
                    addr_pend_valid_reg <= 1'b1;
                end
                if (is_std(setup, `UDR_REQ_SET_CONFIG))
                begin
                    config_reg <= setup.value[7:0];
                    configured_reg <= setup.value[7:0] != `UDR_RST_CONFIG;
                    alt_reg <= 8'h00;
                end
                if (is_std(setup, `UDR_REQ_SET_INTF))
                begin
                    alt_reg <= setup.value[7:0];
                end
                if (is_std(setup, `UDR_REQ_CLEAR_FEATURE))
                begin
                    if (setup.req_type[4:0] == `UDR_RCPT_EP && setup.value == `UDR_FEAT_EP_HALT)
                    begin
                        stall_reg[ep_of(setup.index)] <= 1'b0;
                    end
                    if (setup.req_type[4:0] == `UDR_RCPT_DEVICE && setup.value == `UDR_FEAT_WAKEUP)
                    begin
                        wakeup_reg <= 1'b0;
                    end
                end
                if (is_std(setup, `UDR_REQ_SET_FEATURE))
                begin
                    if (setup.req_type[4:0] == `UDR_RCPT_EP && setup.value == `UDR_FEAT_EP_HALT)
                    begin
                        stall_reg[ep_of(setup.index)] <= 1'b1;
                    end
                    if (setup.req_type[4:0] == `UDR_RCPT_DEVICE && setup.value == `UDR_FEAT_WAKEUP)
                    begin
                        wakeup_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign ack_out = ack_reg;
    assign cmd_out = cmd_reg;
    assign status_stage_out = status_reg;
    assign status_pid_out = status_pid_reg;
    assign dev_addr_out = addr_reg;
    assign config_out = config_reg;
    assign alt_setting_out = alt_reg;
    assign configured_out = configured_reg;
    assign wakeup_en_out = wakeup_reg;
    assign ep_stall_out = stall_reg;
    assign bad_setup_out = bad_reg;

endmodule // udr_decoder

// ==== hdl/udr_map.svh ====
// Constants for the device request decoder: request codes, field values, reset values
`ifndef UDR_MAP_SVH
`define UDR_MAP_SVH

// ----------------------------------------------------------------
// Setup packet layout
// ----------------------------------------------------------------
`define UDR_SETUP_BYTES 4'h8
`define UDR_PID_DATA0 4'h3
`define UDR_PID_DATA1 4'hb
`define UDR_PID_ACK 4'h2

// ----------------------------------------------------------------
// Request type field
// ----------------------------------------------------------------
`define UDR_TYPE_STD 2'h0
`define UDR_TYPE_CLASS 2'h1
`define UDR_TYPE_VENDOR 2'h2
`define UDR_RCPT_DEVICE 5'h00
`define UDR_RCPT_INTF 5'h01
`define UDR_RCPT_EP 5'h02

// ----------------------------------------------------------------
// Standard request codes
// ----------------------------------------------------------------
`define UDR_REQ_GET_STATUS 8'h00
`define UDR_REQ_CLEAR_FEATURE 8'h01
`define UDR_REQ_SET_FEATURE 8'h03
`define UDR_REQ_SET_ADDRESS 8'h05
`define UDR_REQ_GET_DESC 8'h06
`define UDR_REQ_SET_DESC 8'h07
`define UDR_REQ_GET_CONFIG 8'h08
`define UDR_REQ_SET_CONFIG 8'h09
`define UDR_REQ_GET_INTF 8'h0a
`define UDR_REQ_SET_INTF 8'h0b
`define UDR_REQ_SYNC_FRAME 8'h0c

// ----------------------------------------------------------------
// Feature selectors and descriptor types
// ----------------------------------------------------------------
`define UDR_FEAT_EP_HALT 16'h0000
`define UDR_FEAT_WAKEUP 16'h0001
`define UDR_DESC_DEVICE 8'h01
`define UDR_DESC_CONFIG 8'h02
`define UDR_DESC_STRING 8'h03

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UDR_RST_ADDR 7'h00
`define UDR_RST_CONFIG 8'h00

`endif

// ==== hdl/udr_pkg.sv ====
// Types shared by the device request decoder files
package udr_pkg;

    typedef enum logic [1:0] {
        UDR_CAT_STD,
        UDR_CAT_CLASS,
        UDR_CAT_VENDOR,
        UDR_CAT_BAD
    } udr_cat_t;

    typedef enum logic [1:0] {
        UDR_DIR_NONE,
        UDR_DIR_IN,
        UDR_DIR_OUT
    } udr_dir_t;

    typedef struct packed {
        logic [7:0] req_type;
        logic [7:0] request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } udr_setup_t;

    typedef struct packed {
        logic valid;
        udr_cat_t cat;
        udr_dir_t dir;
        logic [7:0] request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
        logic supported;
    } udr_cmd_t;

endpackage

// ==== hdl/udr_setup_buf.sv ====
// Eight-byte setup packet store with registered read-out
`timescale 1ns/10ps

module udr_setup_buf
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    output udr_pkg::udr_setup_t rd_data_out
);

    logic [7:0] mem_reg [0:7];
    udr_pkg::udr_setup_t rd_data_reg;

    // ----------------------------------------------------------------
    // Byte store
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // ----------------------------------------------------------------
    // Registered view, little-endian words
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_data_reg <= '0;
        end
        else
        begin
            rd_data_reg <= {mem_reg[0], mem_reg[1], mem_reg[3], mem_reg[2],
                            mem_reg[5], mem_reg[4], mem_reg[7], mem_reg[6]};
        end
    end

    assign rd_data_out = rd_data_reg;

endmodule // udr_setup_buf

// ==== sim/udr_decoder_properties.sv ====
// Port-level assertions for the device request decoder
`timescale 1ns/10ps
`include "udr_map.svh"

module udr_decoder_properties
#(
    parameter int NUM_EP = 16
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic setup_start_in,
    input wire logic [3:0] pid_in,
    input wire logic pkt_end_in,
    input wire logic status_done_in,
    input wire logic ack_out,
    input wire udr_pkg::udr_cmd_t cmd_out,
    input wire logic status_stage_out,
    input wire logic [3:0] status_pid_out,
    input wire logic [6:0] dev_addr_out,
    input wire logic [7:0] config_out,
    input wire logic configured_out,
    input wire logic wakeup_en_out,
    input wire logic [NUM_EP-1:0] ep_stall_out,
    input wire logic bad_setup_out
);
    // ----------------------------------------------------------------
    // Setup handshake, decode and request effects
    // ----------------------------------------------------------------
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic std_v;
    assign std_v = cmd_out.valid && cmd_out.cat == udr_pkg::UDR_CAT_STD;

    sequence s_pkt_taken;
        pkt_end_in ##1 ack_out;
    endsequence
    sequence s_status_wait;
        status_stage_out && !status_done_in && !setup_start_in;
    endsequence

    a_ack_every_setup: assert property (pkt_end_in |-> s_pkt_taken)
        else $error("setup packet not acknowledged");
    a_ack_only_end: assert property (ack_out |-> $past(pkt_end_in))
        else $error("acknowledge without packet end");
    a_decode_from_setup: assert property (cmd_out.valid |-> $past(pkt_end_in, 3))
        else $error("decode without setup packet");
    a_bad_pid_flagged: assert property (pkt_end_in && pid_in != `UDR_PID_DATA0 |-> ##[1:3] bad_setup_out)
        else $error("wrong data pid not flagged");
    a_get_goes_in: assert property (std_v && cmd_out.request inside {`UDR_REQ_GET_STATUS,
        `UDR_REQ_GET_DESC, `UDR_REQ_GET_CONFIG, `UDR_REQ_GET_INTF} |-> cmd_out.dir == udr_pkg::UDR_DIR_IN)
        else $error("get request without IN stage");
    a_out_stage_set: assert property (std_v && cmd_out.request inside {`UDR_REQ_SET_DESC,
        `UDR_REQ_SYNC_FRAME} |-> cmd_out.dir == udr_pkg::UDR_DIR_OUT)
        else $error("request without OUT stage");
    a_nodata_status: assert property (cmd_out.valid && cmd_out.supported &&
        cmd_out.dir == udr_pkg::UDR_DIR_NONE |-> status_stage_out)
        else $error("no status stage after no-data request");
    a_status_holds: assert property (s_status_wait |=> status_stage_out)
        else $error("status stage dropped early");
    a_stall_applied: assert property (std_v && cmd_out.value == `UDR_FEAT_EP_HALT &&
        cmd_out.request inside {`UDR_REQ_SET_FEATURE, `UDR_REQ_CLEAR_FEATURE} |->
        ep_stall_out[cmd_out.index[3:0]] == (cmd_out.request == `UDR_REQ_SET_FEATURE))
        else $error("endpoint stall not applied");
    a_wakeup_follows: assert property (std_v && cmd_out.value == `UDR_FEAT_WAKEUP &&
        cmd_out.request inside {`UDR_REQ_SET_FEATURE, `UDR_REQ_CLEAR_FEATURE} |->
        wakeup_en_out == (cmd_out.request == `UDR_REQ_SET_FEATURE))
        else $error("remote wakeup not applied");
    a_addr_after_status: assert property (!$stable(dev_addr_out) |-> $past(status_done_in))
        else $error("address changed outside status stage");
    a_config_flag: assert property (configured_out == (config_out != 8'h00))
        else $error("configured flag disagrees with configuration");
    a_status_pid_one: assert property (status_pid_out == `UDR_PID_DATA1)
        else $error("status pid not DATA1");
endmodule // udr_decoder_properties

bind udr_decoder udr_decoder_properties #(.NUM_EP(NUM_EP)) u_props
(
    .clk_in(clk_in),
    .rst_in(rst_in),
    .setup_start_in(setup_start_in),
    .pid_in(pid_in),
    .pkt_end_in(pkt_end_in),
    .status_done_in(status_done_in),
    .ack_out(ack_out),
    .cmd_out(cmd_out),
    .status_stage_out(status_stage_out),
    .status_pid_out(status_pid_out),
    .dev_addr_out(dev_addr_out),
    .config_out(config_out),
    .configured_out(configured_out),
    .wakeup_en_out(wakeup_en_out),
    .ep_stall_out(ep_stall_out),
    .bad_setup_out(bad_setup_out)
);

// ==== sim/udr_host_model.sv ====
// Host side model: sends setup packets and ends status stages
`timescale 1ns/10ps

module udr_host_model
(
    input wire logic clk_in,
    output logic setup_start_out,
    output logic [3:0] pid_out,
    output logic byte_valid_out,
    output logic [7:0] byte_out,
    output logic pkt_end_out,
    output logic status_done_out
);
    // ----------------------------------------------------------------
    // Transfers
    // ----------------------------------------------------------------
    initial
    begin
        setup_start_out = 1'b0;
        pid_out = 4'h0;
        byte_valid_out = 1'b0;
        byte_out = 8'h00;
        pkt_end_out = 1'b0;
        status_done_out = 1'b0;
    end

    // Released lines show the inverse of their last value so stale data never matches
    task automatic send(input udr_pkg::udr_setup_t s, input int nb, input logic [3:0] pid,
                        input int gap);
        logic [63:0] raw;
        raw = {s.length, s.index, s.value, s.request, s.req_type};
        @(negedge clk_in);
        setup_start_out = 1'b1;
        @(negedge clk_in);
        setup_start_out = 1'b0;
        for (int k = 0; k < nb; k++)
        begin
            byte_valid_out = 1'b1;
            byte_out = raw[8*(k%8) +: 8];
            @(negedge clk_in);
            if (gap > 0 || k == nb - 1)
            begin
                byte_valid_out = 1'b0;
                byte_out = ~byte_out;
                repeat (gap) @(negedge clk_in);
            end
        end
        pkt_end_out = 1'b1;
        pid_out = pid;
        @(negedge clk_in);
        pkt_end_out = 1'b0;
        pid_out = ~pid;
    endtask

    task automatic end_status();
        status_done_out = 1'b1;
        @(negedge clk_in);
        status_done_out = 1'b0;
    endtask
endmodule // udr_host_model

// ==== sim/udr_decoder_test.sv ====
// Self-checking bench for the device request decoder
`timescale 1ns/10ps
`include "udr_map.svh"

module udr_decoder_test;
    // ----------------------------------------------------------------
    // Bench, driver and result monitor
    // ----------------------------------------------------------------
    localparam udr_pkg::udr_dir_t D_NONE = udr_pkg::UDR_DIR_NONE;
    localparam udr_pkg::udr_dir_t D_IN = udr_pkg::UDR_DIR_IN;
    localparam udr_pkg::udr_dir_t D_OUT = udr_pkg::UDR_DIR_OUT;
    localparam udr_pkg::udr_cat_t C_STD = udr_pkg::UDR_CAT_STD;
    localparam udr_pkg::udr_cat_t C_CLS = udr_pkg::UDR_CAT_CLASS;
    localparam udr_pkg::udr_cat_t C_VND = udr_pkg::UDR_CAT_VENDOR;
    localparam udr_pkg::udr_cat_t C_BAD = udr_pkg::UDR_CAT_BAD;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic setup_start, byte_valid, pkt_end, status_done, ack, status_stage;
    logic configured, wakeup_en, bad_setup;
    logic [3:0] pid, status_pid;
    logic [7:0] byte_v, cfg, alt;
    logic [6:0] dev_addr, addr_pre;
    logic [15:0] ep_stall;
    udr_pkg::udr_cmd_t cmd;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [12:0] exp_q[$];

    always #20 clk_in = ~clk_in;

    udr_decoder #(.NUM_EP(16)) dut
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .setup_start_in(setup_start),
        .pid_in(pid),
        .byte_valid_in(byte_valid),
        .byte_in(byte_v),
        .pkt_end_in(pkt_end),
        .status_done_in(status_done),
        .ack_out(ack),
        .cmd_out(cmd),
        .status_stage_out(status_stage),
        .status_pid_out(status_pid),
        .dev_addr_out(dev_addr),
        .config_out(cfg),
        .alt_setting_out(alt),
        .configured_out(configured),
        .wakeup_en_out(wakeup_en),
        .ep_stall_out(ep_stall),
        .bad_setup_out(bad_setup)
    );

    udr_host_model host
    (
        .clk_in(clk_in),
        .setup_start_out(setup_start),
        .pid_out(pid),
        .byte_valid_out(byte_valid),
        .byte_out(byte_v),
        .pkt_end_out(pkt_end),
        .status_done_out(status_done)
    );

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
                        input logic [15:0] idx, input logic [15:0] len, input int nb,
                        input logic [3:0] p, input udr_pkg::udr_cat_t c,
                        input udr_pkg::udr_dir_t d, input logic sup);
        int w;
        logic good;
        good = (nb == 8) && (p == `UDR_PID_DATA0);
        w = 0;
        if (good)
            exp_q.push_back({c, d, sup, rq});
        host.send({rt, rq, val, idx, len}, nb, p, $urandom_range(1, 0));
        while (ack !== 1'b1 && w < 8)
        begin
            @(negedge clk_in);
            w++;
        end
        if (w == 8)
        begin
            n_mismatch++;
            results();
        end
        chk("ack", 1'b1, ack);
        repeat (3) @(negedge clk_in);
        chk("bad_setup", !good, bad_setup);
        chk("status_stage", good && d == D_NONE, status_stage);
        addr_pre = dev_addr;
        host.end_status();
        @(negedge clk_in);
        chk("status_stage", 1'b0, status_stage);
    endtask

    task automatic std_req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
                           input logic [15:0] idx, input logic [15:0] len,
                           input udr_pkg::udr_dir_t d);
        xfer(rt, rq, val, idx, len, 8, `UDR_PID_DATA0, C_STD, d, 1'b1);
    endtask

    // Decoded results are matched in issue order; a stray pulse counts as a mismatch
    always @(negedge clk_in)
        if (rst_in === 1'b0 && cmd.valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("cmd_unexpected", 16'h0000, 16'h0001);
            else
                chk("cmd", exp_q.pop_front(), {cmd.cat, cmd.dir, cmd.supported, cmd.request});
        end

    initial
    begin
        int r;
        logic [6:0] a;
        logic [7:0] c;
        logic [15:0] ep;
        r = $urandom(4775);
        a = 7'($urandom_range(127, 1));
        c = 8'($urandom_range(255, 1));
        ep = 16'($urandom_range(15, 1));
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk("status_pid", `UDR_PID_DATA1, status_pid);
        chk("dev_addr", `UDR_RST_ADDR, dev_addr);
        chk("config", `UDR_RST_CONFIG, cfg);
        chk("wakeup", 1'b0, wakeup_en);
        chk("ep_stall", 16'h0000, ep_stall);
        xfer(8'h40, 8'h5a, 16'h0000, 16'h0000, 16'h0000, 8, `UDR_PID_DATA0, C_VND, D_NONE, 1'b0);
        std_req(8'h00, `UDR_REQ_SET_CONFIG, {8'h00, c}, 16'h0000, 16'h0000, D_NONE);
        chk("configured", 1'b1, configured);
        chk("config", c, cfg);
        std_req(8'h80, `UDR_REQ_GET_CONFIG, 16'h0000, 16'h0000, 16'h0001, D_IN);
        std_req(8'h01, `UDR_REQ_SET_INTF, 16'h0003, 16'h0000, 16'h0000, D_NONE);
        chk("alt", 8'h03, alt);
        std_req(8'h81, `UDR_REQ_GET_INTF, 16'h0000, 16'h0000, 16'h0001, D_IN);
        for (int i = 1; i <= 3; i++)
        begin
            std_req(8'h80, `UDR_REQ_GET_DESC, {8'(i), 8'h00}, 16'h0000, 16'h0012, D_IN);
            std_req(8'h00, `UDR_REQ_SET_DESC, {8'(i), 8'h00}, 16'h0000, 16'h0012, D_OUT);
            std_req(8'h7f + 8'(i), `UDR_REQ_GET_STATUS, 16'h0000, ep, 16'h0002, D_IN);
        end
        std_req(8'h82, `UDR_REQ_SYNC_FRAME, 16'h0000, ep, 16'h0002, D_OUT);
        std_req(8'h02, `UDR_REQ_SET_FEATURE, `UDR_FEAT_EP_HALT, ep, 16'h0000, D_NONE);
        chk("ep_stall", 16'h0001 << ep, ep_stall);
        std_req(8'h02, `UDR_REQ_CLEAR_FEATURE, `UDR_FEAT_EP_HALT, ep, 16'h0000, D_NONE);
        chk("ep_stall", 16'h0000, ep_stall);
        std_req(8'h00, `UDR_REQ_SET_FEATURE, `UDR_FEAT_WAKEUP, 16'h0000, 16'h0000, D_NONE);
        chk("wakeup", 1'b1, wakeup_en);
        std_req(8'h00, `UDR_REQ_CLEAR_FEATURE, `UDR_FEAT_WAKEUP, 16'h0000, 16'h0000, D_NONE);
        chk("wakeup", 1'b0, wakeup_en);
        std_req(8'h00, `UDR_REQ_SET_ADDRESS, {9'h000, a}, 16'h0000, 16'h0000, D_NONE);
        chk("addr_before_status", `UDR_RST_ADDR, addr_pre);
        chk("dev_addr", a, dev_addr);
        xfer(8'ha1, 8'h01, 16'h0000, 16'h0000, 16'h0008, 8, `UDR_PID_DATA0, C_CLS, D_IN, 1'b1);
        xfer(8'h41, 8'h22, 16'h0000, 16'h0000, 16'h0004, 8, `UDR_PID_DATA0, C_VND, D_OUT, 1'b1);
        xfer(8'h60, 8'h10, 16'h0000, 16'h0000, 16'h0000, 8, `UDR_PID_DATA0, C_BAD, D_NONE, 1'b0);
        xfer(8'h00, 8'h02, 16'h0000, 16'h0000, 16'h0000, 8, `UDR_PID_DATA0, C_STD, D_NONE, 1'b0);
        xfer(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 7, `UDR_PID_DATA0, C_STD, D_IN, 1'b1);
        xfer(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 8, `UDR_PID_DATA1, C_STD, D_IN, 1'b1);
        repeat (4) @(negedge clk_in);
        chk("results_left", 16'h0000, 16'(exp_q.size()));
        results();
    end
endmodule // udr_decoder_test
